// ### core/cmt_pkg.sv
// shared types and constants of the mailbox and timer unit
// assumes a frame engine on the same clock delivers decoded frames and bit ticks
package cmt_pkg;
  localparam int NMB        = 8;
  localparam int TW         = 16;
  localparam int IDW        = 29;
  localparam int STD_LSB    = 18;
  localparam int DW         = 64;
  localparam int PRW        = 4;
  localparam logic [15:0] TMR_MAX  = 16'hFFFF;
  localparam logic [15:0] TMR_ZERO = 16'h0000;
  localparam logic [15:0] TMR_ONE  = 16'h0001;

  // mailbox object types
  typedef enum logic [2:0] {
    OBJ_DISABLED = 3'h0,
    OBJ_RX       = 3'h1,
    OBJ_RX_OVR   = 3'h2,
    OBJ_CONSUMER = 3'h3,
    OBJ_TX       = 3'h4,
    OBJ_PRODUCER = 3'h5
  } cmt_obj_t;

  typedef struct packed {
    cmt_obj_t         mailbox_object_type_field;
    logic [PRW-1:0]   tx_priority_field;
    logic             extended_id_select;
    logic [IDW-1:0]   id;
    logic [IDW-1:0]   acceptance_mask;
    logic [TW-1:0]    trigger;
    logic [3:0]       dlc;
    logic [DW-1:0]    data;
  } cmt_mb_cfg_t;

  typedef struct packed {
    logic             ide;
    logic             rtr;
    logic [IDW-1:0]   id;
    logic [3:0]       dlc;
    logic [DW-1:0]    data;
  } cmt_frame_t;

  typedef struct packed {
    logic             controller_enable_bit;
    logic             low_power_request;
    logic             timer_hold_bit;
    logic             capture_at_frame_end;
    logic             time_triggered_select;
  } cmt_ctrl_t;

  typedef enum logic [1:0] {
    TXS_IDLE  = 2'b00,
    TXS_OFFER = 2'b01
  } cmt_txs_t;
endpackage

// ### core/cmt_unit.sv
// mailbox layer and time management unit of a CAN controller
// assumes the frame engine and software strobes share core_clk; bit_tick is one
// pulse per CAN bit time; all strobes are one-cycle pulses
// Functional notes
// - eight mailboxes, each typed and identified independently
// - extended select chooses extended or standard identifiers
// - masked compare; accepted identifier written back
// - uncompared bits packed low into family id
// - lowest-numbered available matching receive mailbox stores
// - plain receive locks until next transfer request
// - overwrite receive stores every accepted message
// - consumer sends remote, keeps first answer
// - chained equal-id mailboxes fill in turn
// - highest priority pending transmit offered first
// - time-triggered transmit waits for trigger time
// - per-mailbox sent or aborted report
// - producer answers matching remote frame automatically
// - 16-bit timer ticks per bit while enabled
// - timer clears on sleep, disable, and on last-mailbox ready in time-triggered mode
// - clear strobe resets timer; value always readable
// - rollover sets wrap flag, read clears, irq
// - hold stops timer at all-ones, raises overflow
// - capture at frame end or start, flag
// - timestamping or trigger-on-equal mode select
`timescale 1ns/1ps
module cmt_unit #(
  parameter int NMB = cmt_pkg::NMB
) (
  // clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                reset_n,
  // configuration
  input  wire cmt_pkg::cmt_ctrl_t                  controller_config_reg,
  input  wire cmt_pkg::cmt_mb_cfg_t [NMB-1:0]      mailbox_config_reg,
  input  wire logic                                sleep_state,
  // software strobes and interrupt mask
  input  wire logic [NMB-1:0]                      transfer_request,
  input  wire logic                                timer_clear_bit,
  input  wire logic                                status_read,
  input  wire logic [1:0]                          irq_mask_reg,
  // frame engine
  input  wire logic                                bit_tick,
  input  wire logic                                frame_start,
  input  wire logic                                frame_end,
  input  wire logic                                rx_valid,
  input  wire cmt_pkg::cmt_frame_t                 rx_frame,
  input  wire logic                                tx_done,
  input  wire logic                                tx_abort,
  output logic                                     tx_valid,
  output cmt_pkg::cmt_frame_t                      tx_frame,
  output logic [$clog2(NMB)-1:0]                   tx_mailbox,
  // mailbox state
  output logic [NMB-1:0][cmt_pkg::IDW-1:0]         mailbox_id_reg,
  output logic [NMB-1:0][cmt_pkg::IDW-1:0]         family_id_reg,
  output logic [NMB-1:0][cmt_pkg::DW-1:0]          mailbox_data_reg,
  output logic [NMB-1:0][3:0]                      mailbox_dlc_reg,
  output logic [NMB-1:0]                           message_ready_flag,
  output logic [NMB-1:0]                           tx_sent_flag,
  output logic [NMB-1:0]                           tx_aborted_flag,
  // timer and status
  output logic [cmt_pkg::TW-1:0]                   timer_value_reg,
  output logic [cmt_pkg::TW-1:0]                   frame_time_capture_reg,
  output logic                                     timer_wrap_flag,
  output logic                                     capture_event_flag,
  output logic                                     irq
);
  localparam int MBW = $clog2(NMB);
  localparam logic [MBW-1:0] LAST_MB = MBW'(NMB - 1);

  logic rst_sync1_reg, rst_n_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync1_reg <= 1'b0;
      rst_n_reg     <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n_reg     <= rst_sync1_reg;
    end
  end

  // compared field: whole identifier for extended, top bits for standard
  function automatic logic [cmt_pkg::IDW-1:0] field_mask(input logic ext);
    field_mask = ext ? {cmt_pkg::IDW{1'b1}}
                     : {{(cmt_pkg::IDW-cmt_pkg::STD_LSB){1'b1}}, {cmt_pkg::STD_LSB{1'b0}}};
  endfunction

  function automatic logic id_match(input cmt_pkg::cmt_mb_cfg_t c, input cmt_pkg::cmt_frame_t f);
    logic [cmt_pkg::IDW-1:0] m;
    m = c.acceptance_mask & field_mask(c.extended_id_select);
    id_match = (c.extended_id_select == f.ide) && ((f.id & m) == (c.id & m));
  endfunction

  // gather uncompared bits in order, lowest first
  function automatic logic [cmt_pkg::IDW-1:0] family_of(input cmt_pkg::cmt_mb_cfg_t c,
                                                        input logic [cmt_pkg::IDW-1:0] id);
    logic [cmt_pkg::IDW-1:0] fm;
    logic [4:0]              k;
    family_of = '0;
    fm = ~c.acceptance_mask & field_mask(c.extended_id_select);
    k = 5'h00;
    for (int b = 0; b < cmt_pkg::IDW; b++) begin
      if (fm[b]) begin
        family_of[k] = id[b];
        k = k + 5'h01;
      end
    end
  endfunction

  function automatic logic [MBW-1:0] lowest(input logic [NMB-1:0] v);
    lowest = '0;
    for (int i = NMB - 1; i >= 0; i--) begin
      if (v[i]) lowest = MBW'(i);
    end
  endfunction

  // mailbox state
  logic [NMB-1:0] pend_reg, trig_hit_reg, prod_arm_reg, ready_last_d_reg;
  logic [NMB-1:0] avail, hit_data, hit_remote, eligible, is_rx_type;
  logic           store_en, tt_on;
  logic [MBW-1:0] store_mb, win_mb;
  cmt_pkg::cmt_txs_t txs_reg;

  assign tt_on = controller_config_reg.time_triggered_select;

  for (genvar g = 0; g < NMB; g++) begin : g_dec
    cmt_pkg::cmt_obj_t obj;
    assign obj = mailbox_config_reg[g].mailbox_object_type_field;
    assign is_rx_type[g] = (obj == cmt_pkg::OBJ_RX) || (obj == cmt_pkg::OBJ_RX_OVR)
                         || (obj == cmt_pkg::OBJ_CONSUMER);
    // locked mailboxes drop out so chained ones fill in turn
    assign avail[g] = (obj == cmt_pkg::OBJ_RX_OVR)
                    || ((obj == cmt_pkg::OBJ_RX) && !message_ready_flag[g])
                    || ((obj == cmt_pkg::OBJ_CONSUMER) && !message_ready_flag[g]
                        && !pend_reg[g]);
    assign hit_data[g] = rx_valid && !rx_frame.rtr && avail[g]
                       && id_match(mailbox_config_reg[g], rx_frame);
    assign hit_remote[g] = rx_valid && rx_frame.rtr && (obj == cmt_pkg::OBJ_PRODUCER)
                         && prod_arm_reg[g] && id_match(mailbox_config_reg[g], rx_frame);
    assign eligible[g] = pend_reg[g] && (!tt_on || trig_hit_reg[g]);
  end

  assign store_en = |hit_data;
  assign store_mb = lowest(hit_data);

  // highest priority is the smallest field value; ties go to the lower index
  logic [MBW-1:0] best_mb;
  always_comb begin
    logic [cmt_pkg::PRW-1:0] bp;
    logic                    found;
    best_mb = '0;
    bp      = '1;
    found   = 1'b0;
    for (int i = 0; i < NMB; i++) begin
      if (eligible[i] && (!found || mailbox_config_reg[i].tx_priority_field < bp)) begin
        best_mb = MBW'(i);
        bp      = mailbox_config_reg[i].tx_priority_field;
        found   = 1'b1;
      end
    end
  end
  assign win_mb = best_mb;

  logic tx_finish;
  assign tx_finish = (txs_reg == cmt_pkg::TXS_OFFER) && (tx_done || tx_abort);

  for (genvar g = 0; g < NMB; g++) begin : g_mb
    logic is_tx_g, req_g, fin_g, st_g;
    cmt_pkg::cmt_obj_t obj;
    assign obj     = mailbox_config_reg[g].mailbox_object_type_field;
    assign req_g   = transfer_request[g];
    assign fin_g   = tx_finish && (tx_mailbox == MBW'(g));
    assign st_g    = store_en && (store_mb == MBW'(g));
    assign is_tx_g = (obj == cmt_pkg::OBJ_TX) || (obj == cmt_pkg::OBJ_CONSUMER);
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        pend_reg[g]           <= 1'b0;
        trig_hit_reg[g]       <= 1'b0;
        prod_arm_reg[g]       <= 1'b0;
        message_ready_flag[g] <= 1'b0;
        tx_sent_flag[g]       <= 1'b0;
        tx_aborted_flag[g]    <= 1'b0;
        mailbox_id_reg[g]     <= '0;
        family_id_reg[g]      <= '0;
        mailbox_data_reg[g]   <= '0;
        mailbox_dlc_reg[g]    <= '0;
      end else begin
        if (st_g) begin
          mailbox_id_reg[g]   <= rx_frame.id;
          family_id_reg[g]    <= family_of(mailbox_config_reg[g], rx_frame.id);
          mailbox_data_reg[g] <= rx_frame.data;
          mailbox_dlc_reg[g]  <= rx_frame.dlc;
        end
        // a store in the same cycle as a request wins
        message_ready_flag[g] <= st_g || (message_ready_flag[g] && !(req_g && is_rx_type[g]));
        prod_arm_reg[g] <= (req_g && obj == cmt_pkg::OBJ_PRODUCER)
                        || (prod_arm_reg[g] && !hit_remote[g]);
        pend_reg[g] <= (req_g && is_tx_g) || hit_remote[g] || (pend_reg[g] && !fin_g);
        trig_hit_reg[g] <= pend_reg[g] && !fin_g && (trig_hit_reg[g]
                        || (timer_value_reg == mailbox_config_reg[g].trigger));
        tx_sent_flag[g]    <= (fin_g && tx_done) || (tx_sent_flag[g] && !req_g);
        tx_aborted_flag[g] <= (fin_g && !tx_done) || (tx_aborted_flag[g] && !req_g);
      end
    end
  end

  // transmit offer
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      txs_reg    <= cmt_pkg::TXS_IDLE;
      tx_valid   <= 1'b0;
      tx_frame   <= '0;
      tx_mailbox <= '0;
    end else begin
      case (txs_reg)
        cmt_pkg::TXS_IDLE: begin
          if (|eligible) begin
            txs_reg        <= cmt_pkg::TXS_OFFER;
            tx_valid       <= 1'b1;
            tx_mailbox     <= win_mb;
            tx_frame.ide   <= mailbox_config_reg[win_mb].extended_id_select;
            tx_frame.rtr   <= mailbox_config_reg[win_mb].mailbox_object_type_field
                              == cmt_pkg::OBJ_CONSUMER;
            tx_frame.id    <= mailbox_config_reg[win_mb].id;
            tx_frame.dlc   <= mailbox_config_reg[win_mb].dlc;
            tx_frame.data  <= mailbox_config_reg[win_mb].data;
          end
        end
        cmt_pkg::TXS_OFFER: begin
          if (tx_done || tx_abort) begin
            txs_reg  <= cmt_pkg::TXS_IDLE;
            tx_valid <= 1'b0;
          end
        end
        default: begin
          txs_reg  <= cmt_pkg::TXS_IDLE;
          tx_valid <= 1'b0;
        end
      endcase
    end
  end

  // time management
  logic tmr_clr, tmr_inc, wrap_evt, cap_evt, last_rise, at_max;
  assign last_rise = message_ready_flag[LAST_MB] && !ready_last_d_reg[LAST_MB];
  assign at_max  = timer_value_reg == cmt_pkg::TMR_MAX;
  assign tmr_clr = !controller_config_reg.controller_enable_bit
                 || (controller_config_reg.low_power_request && sleep_state)
                 || timer_clear_bit
                 || (tt_on && last_rise);
  assign tmr_inc = bit_tick && !(controller_config_reg.timer_hold_bit && at_max);
  // with hold the event fires on reaching all-ones, else on rollover
  assign wrap_evt = !tmr_clr && bit_tick && (controller_config_reg.timer_hold_bit
                  ? (timer_value_reg == cmt_pkg::TMR_MAX - cmt_pkg::TMR_ONE) : at_max);
  assign cap_evt = controller_config_reg.capture_at_frame_end ? frame_end : frame_start;

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      timer_value_reg        <= cmt_pkg::TMR_ZERO;
      frame_time_capture_reg <= cmt_pkg::TMR_ZERO;
      timer_wrap_flag        <= 1'b0;
      capture_event_flag     <= 1'b0;
      irq                    <= 1'b0;
      ready_last_d_reg       <= '0;
    end else begin
      ready_last_d_reg <= message_ready_flag;
      if (tmr_clr) begin
        timer_value_reg <= cmt_pkg::TMR_ZERO;
      end else if (tmr_inc) begin
        timer_value_reg <= timer_value_reg + cmt_pkg::TMR_ONE;
      end
      if (cap_evt) begin
        frame_time_capture_reg <= timer_value_reg;
      end
      // the setting event wins over a status read
      timer_wrap_flag    <= wrap_evt || (timer_wrap_flag && !status_read);
      capture_event_flag <= cap_evt || (capture_event_flag && !status_read);
      irq <= (timer_wrap_flag && irq_mask_reg[0]) || (capture_event_flag && irq_mask_reg[1]);
    end
  end

  // checks
  sequence s_tick_at_max;
    bit_tick && at_max && !tmr_clr && !controller_config_reg.timer_hold_bit;
  endsequence
  sequence s_offer_open;
    txs_reg == cmt_pkg::TXS_IDLE && |eligible;
  endsequence
  sequence s_offer_remote;
    txs_reg == cmt_pkg::TXS_IDLE && |eligible
      && mailbox_config_reg[win_mb].mailbox_object_type_field == cmt_pkg::OBJ_CONSUMER;
  endsequence

  a_wrap_on_roll: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    s_tick_at_max |=> timer_wrap_flag && timer_value_reg == cmt_pkg::TMR_ZERO)
    else $error("rollover did not set wrap flag");
  a_hold_at_max: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    controller_config_reg.timer_hold_bit && at_max && !tmr_clr |=> at_max)
    else $error("held timer left all-ones");
  a_timer_clear: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    tmr_clr |=> timer_value_reg == cmt_pkg::TMR_ZERO)
    else $error("timer not cleared");
  a_timer_count: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    !tmr_clr && !bit_tick |=> $stable(timer_value_reg))
    else $error("timer moved without a bit tick");
  a_capture_value: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    cap_evt |=> frame_time_capture_reg == $past(timer_value_reg) && capture_event_flag)
    else $error("capture value or flag wrong");
  a_store_lowest: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    store_en |=> message_ready_flag[$past(store_mb)]
      && mailbox_id_reg[$past(store_mb)] == $past(rx_frame.id))
    else $error("frame not stored in chosen mailbox");
  a_rx_locked: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    store_en |-> !(message_ready_flag[store_mb]
      && mailbox_config_reg[store_mb].mailbox_object_type_field == cmt_pkg::OBJ_RX))
    else $error("locked receive mailbox overwritten");
  a_offer_win: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    s_offer_open |=> tx_valid && tx_mailbox == $past(win_mb))
    else $error("wrong mailbox offered");
  a_offer_holds: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    tx_valid && !tx_done && !tx_abort |=> tx_valid && $stable(tx_mailbox))
    else $error("offer dropped before completion");
  a_tt_wait: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    s_offer_open and tt_on |-> trig_hit_reg[win_mb])
    else $error("triggered mailbox sent before its time");
  a_irq_follow: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    timer_wrap_flag && irq_mask_reg[0] |=> irq)
    else $error("enabled wrap flag gave no interrupt");
  a_remote_offer: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    s_offer_remote |=> tx_valid && tx_frame.rtr)
    else $error("consumer offer was not a remote frame");
  a_timer_step: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    !tmr_clr && tmr_inc |=> timer_value_reg == $past(timer_value_reg) + cmt_pkg::TMR_ONE)
    else $error("timer did not advance by one");
  a_sent_flag: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    tx_finish && tx_done |=> tx_sent_flag[$past(tx_mailbox)] && !tx_valid)
    else $error("completed offer not reported");
  a_remote_arm: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    |hit_remote |=> (pend_reg & $past(hit_remote)) == $past(hit_remote))
    else $error("remote frame did not start producer answer");
  a_wrap_clear: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    status_read && !wrap_evt |=> !timer_wrap_flag)
    else $error("status read left wrap flag set");
endmodule

// ### verif/cmt_bus_model.sv
// far-side model: frame engine and bus nodes feeding the mailbox unit
// assumes core_clk is shared with the unit; all strobes change 1 ns after a rising edge
`timescale 1ns/1ps
module cmt_bus_model (
  // clock
  input  wire logic          core_clk,
  // offer from the unit
  input  wire logic          tx_valid,
  input  wire logic [2:0]    tx_mailbox,
  // engine strobes
  output logic               bit_tick,
  output logic               frame_start,
  output logic               frame_end,
  output logic               rx_valid,
  output cmt_pkg::cmt_frame_t rx_frame,
  output logic               tx_done,
  output logic               tx_abort
);
  int         delay      = 2;
  logic       abort_next = 1'b0;
  logic [2:0] mb_q[$];

  initial begin
    {bit_tick, frame_start, frame_end, rx_valid, tx_done, tx_abort} = '0;
    rx_frame = '0;
  end

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1 bit_tick = 1'b1;
    end
    @(posedge core_clk);
    #1 bit_tick = 1'b0;
  endtask

  // two bit times inside the frame so start and end captures differ
  task automatic send(input cmt_pkg::cmt_frame_t f);
    @(posedge core_clk);
    #1 frame_start = 1'b1;
    @(posedge core_clk);
    #1 frame_start = 1'b0;
    ticks(2);
    rx_valid = 1'b1;
    rx_frame = f;
    @(posedge core_clk);
    #1 rx_valid = 1'b0;
    rx_frame  = ~f;
    frame_end = 1'b1;
    @(posedge core_clk);
    #1 frame_end = 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  // one offer at a time; aborts only when the bench asks for it
  initial forever begin
    @(posedge core_clk);
    #1;
    if (tx_valid === 1'b1) begin
      mb_q.push_back(tx_mailbox);
      repeat (delay) @(posedge core_clk);
      #1;
      if (abort_next) tx_abort = 1'b1;
      else tx_done = 1'b1;
      abort_next = 1'b0;
      @(posedge core_clk);
      #1 tx_done = 1'b0;
      tx_abort = 1'b0;
    end
  end
endmodule

// ### verif/testbench.sv
// self-checking bench of the mailbox and timer unit
// assumes cmt_bus_model stands in for the frame engine; one 40 MHz clock
`timescale 1ns/1ps
module testbench;
  localparam logic [28:0] IDB = 29'h02468AC0;
  localparam logic [28:0] MSK = 29'h1FFFFFF3;
  localparam logic [28:0] ALL = 29'h1FFFFFFF;
  logic                       core_clk = 1'b0;
  logic                       reset_n  = 1'b0;
  cmt_pkg::cmt_ctrl_t         ctl      = '0;
  cmt_pkg::cmt_mb_cfg_t [7:0] mb       = '0;
  logic                       sleep_state = 1'b0;
  logic                       timer_clear_bit = 1'b0;
  logic                       status_read = 1'b0;
  logic [7:0]                 transfer_request = '0;
  logic [1:0]                 irq_mask_reg = '0;
  logic                       bit_tick, frame_start, frame_end, rx_valid;
  logic                       tx_done, tx_abort, tx_valid, irq;
  logic                       timer_wrap_flag, capture_event_flag;
  cmt_pkg::cmt_frame_t        rx_frame, tx_frame;
  logic [2:0]                 tx_mailbox;
  logic [7:0][28:0]           mid, fid;
  logic [7:0][63:0]           mdata;
  logic [7:0][3:0]            mdlc;
  logic [7:0]                 ready, sent, aborted;
  logic [15:0]                tval, tcap;
  int                         err_total = 0, samples_checked = 0, cycles = 0;

  cmt_unit cmt_unit_i (.core_clk, .reset_n, .controller_config_reg(ctl),
    .mailbox_config_reg(mb), .sleep_state, .transfer_request, .timer_clear_bit,
    .status_read, .irq_mask_reg, .bit_tick, .frame_start, .frame_end, .rx_valid,
    .rx_frame, .tx_done, .tx_abort, .tx_valid, .tx_frame, .tx_mailbox,
    .mailbox_id_reg(mid), .family_id_reg(fid), .mailbox_data_reg(mdata),
    .mailbox_dlc_reg(mdlc), .message_ready_flag(ready), .tx_sent_flag(sent),
    .tx_aborted_flag(aborted), .timer_value_reg(tval), .frame_time_capture_reg(tcap),
    .timer_wrap_flag, .capture_event_flag, .irq);
  cmt_bus_model cmt_bus_model_i (.core_clk, .tx_valid, .tx_mailbox, .bit_tick,
    .frame_start, .frame_end, .rx_valid, .rx_frame, .tx_done, .tx_abort);

  always #12.5 core_clk = ~core_clk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ceiling covers the full-range timer walk plus margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 90000) begin
      err_total++;
      $display("[ERR] timeout exp below 90000 seen %0d", cycles);
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(2);
  endtask

  task automatic req(input logic [7:0] m);
    transfer_request = m;
    cyc(1);
    transfer_request = '0;
    cyc(1);
  endtask

  task automatic tk(input int n);
    cmt_bus_model_i.ticks(n);
    cyc(3);
  endtask

  task automatic send(input logic ide, input logic rtr, input logic [28:0] id,
                      input logic [63:0] d);
    cmt_bus_model_i.send({ide, rtr, id, 4'h8, d});
  endtask

  task automatic wait_tx();
    int n;
    n = 0;
    while (tx_valid !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("tx_valid", tx_valid, 1'b1);
  endtask

  function automatic cmt_pkg::cmt_mb_cfg_t cfg(cmt_pkg::cmt_obj_t t, logic [3:0] p,
      logic [28:0] id, logic [28:0] m, logic [15:0] trg, logic [63:0] d);
    cfg = {t, p, 1'b1, id, m, trg, 4'h8, d};
  endfunction

  // full reset between scenarios so no mailbox state leaks across
  task automatic rst();
    reset_n = 1'b0;
    mb = '0;
    ctl = '0;
    irq_mask_reg = '0;
    cmt_bus_model_i.mb_q.delete();
    cmt_bus_model_i.delay = 2;
    cyc(5);
    reset_n = 1'b1;
    cyc(4);
  endtask

  task automatic t_rx();
    rst();
    mb[1] = cfg(cmt_pkg::OBJ_RX, 4'h0, IDB, MSK, 16'h0000, 64'h0);
    mb[2] = cfg(cmt_pkg::OBJ_RX_OVR, 4'h0, IDB, MSK, 16'h0000, 64'h0);
    send(1'b0, 1'b0, IDB, 64'h11);
    chk("ready", ready, 8'h00);
    send(1'b1, 1'b0, IDB | 29'h8, 64'h22);
    chk("id1", mid[1], IDB | 29'h8);
    chk("fam1", fid[1], 29'h2);
    chk("dlc1", mdlc[1], 4'h8);
    chk("ready", ready, 8'h02);
    send(1'b1, 1'b0, IDB | 29'h4, 64'h33);
    chk("data1", mdata[1], 64'h22);
    chk("fam2", fid[2], 29'h1);
    send(1'b1, 1'b0, IDB | 29'hC, 64'h44);
    chk("data2", mdata[2], 64'h44);
    chk("fam2", fid[2], 29'h3);
    send(1'b1, 1'b0, IDB ^ 29'h100, 64'h55);
    chk("data2", mdata[2], 64'h44);
    req(8'h02);
    chk("ready", ready, 8'h04);
    send(1'b1, 1'b0, IDB, 64'h66);
    chk("data1", mdata[1], 64'h66);
  endtask

  task automatic t_tx();
    rst();
    ctl.controller_enable_bit = 1'b1;
    mb[2] = cfg(cmt_pkg::OBJ_TX, 4'h8, 29'h2, ALL, 16'h0000, 64'h2);
    mb[4] = cfg(cmt_pkg::OBJ_TX, 4'h3, 29'h4, ALL, 16'h0000, 64'h4);
    mb[5] = cfg(cmt_pkg::OBJ_TX, 4'h1, 29'h5, ALL, 16'h0000, 64'h5A5A);
    mb[6] = cfg(cmt_pkg::OBJ_TX, 4'h1, 29'h6, ALL, 16'h0000, 64'h6);
    cmt_bus_model_i.delay = 3;
    cmt_bus_model_i.abort_next = 1'b1;
    req(8'h74);
    wait_tx();
    chk("txmb", tx_mailbox, 3'h5);
    chk("txdata", tx_frame.data, 64'h5A5A);
    cyc(40);
    chk("ntx", cmt_bus_model_i.mb_q.size(), 4);
    chk("order", {cmt_bus_model_i.mb_q[0], cmt_bus_model_i.mb_q[1],
        cmt_bus_model_i.mb_q[2], cmt_bus_model_i.mb_q[3]}, 12'hBA2);
    chk("sent", sent, 8'h54);
    chk("aborted", aborted, 8'h20);
  endtask

  task automatic t_remote();
    rst();
    ctl.controller_enable_bit = 1'b1;
    // slow engine answer so the producer offer still stands when looked at
    cmt_bus_model_i.delay = 4;
    mb[3] = cfg(cmt_pkg::OBJ_CONSUMER, 4'h0, 29'h333, ALL, 16'h0000, 64'h0);
    mb[7] = cfg(cmt_pkg::OBJ_PRODUCER, 4'h0, 29'h777, ALL, 16'h0000, 64'hBEEF);
    req(8'h08);
    wait_tx();
    chk("rtr", tx_frame.rtr, 1'b1);
    chk("rid", tx_frame.id, 29'h333);
    cyc(4);
    send(1'b1, 1'b0, 29'h333, 64'hA1);
    send(1'b1, 1'b0, 29'h333, 64'hA2);
    chk("cdata", mdata[3], 64'hA1);
    req(8'h80);
    cyc(4);
    chk("tx_valid", tx_valid, 1'b0);
    send(1'b1, 1'b1, 29'h777, 64'h0);
    wait_tx();
    chk("pmb", tx_mailbox, 3'h7);
    chk("pdata", tx_frame.data, 64'hBEEF);
  endtask

  task automatic t_tt();
    rst();
    ctl.controller_enable_bit = 1'b1;
    ctl.time_triggered_select = 1'b1;
    mb[4] = cfg(cmt_pkg::OBJ_TX, 4'h0, 29'h44, ALL, 16'h0006, 64'h0);
    mb[7] = cfg(cmt_pkg::OBJ_RX, 4'h0, 29'h7F, ALL, 16'h0000, 64'h0);
    req(8'h10);
    tk(5);
    chk("ttwait", tx_valid, 1'b0);
    cmt_bus_model_i.ticks(1);
    wait_tx();
    chk("tttime", tval, 16'h0006);
    cyc(6);
    send(1'b1, 1'b0, 29'h7F, 64'h0);
    cyc(2);
    chk("ttclr", tval, 16'h0000);
  endtask

  task automatic t_capture();
    rst();
    ctl.controller_enable_bit = 1'b1;
    irq_mask_reg = 2'b10;
    tk(7);
    send(1'b1, 1'b0, 29'h1, 64'h0);
    chk("cap", tcap, 16'h0007);
    chk("capf", capture_event_flag, 1'b1);
    cyc(1);
    chk("irq", irq, 1'b1);
    pulse(status_read);
    chk("capf", capture_event_flag, 1'b0);
    ctl.capture_at_frame_end = 1'b1;
    send(1'b1, 1'b0, 29'h1, 64'h0);
    chk("cap", tcap, 16'h000B);
  endtask

  task automatic t_timer();
    rst();
    ctl.controller_enable_bit = 1'b1;
    irq_mask_reg = 2'b01;
    tk(5);
    chk("tim", tval, 16'h0005);
    ctl.controller_enable_bit = 1'b0;
    tk(3);
    chk("tim", tval, 16'h0000);
    ctl.controller_enable_bit = 1'b1;
    tk(3);
    pulse(timer_clear_bit);
    chk("tim", tval, 16'h0000);
    tk(2);
    ctl.low_power_request = 1'b1;
    sleep_state = 1'b1;
    cyc(3);
    chk("tim", tval, 16'h0000);
    ctl.low_power_request = 1'b0;
    sleep_state = 1'b0;
    tk(65534);
    chk("wrap", timer_wrap_flag, 1'b0);
    ctl.timer_hold_bit = 1'b1;
    tk(3);
    chk("tim", tval, 16'hFFFF);
    chk("wrap", timer_wrap_flag, 1'b1);
    chk("irq", irq, 1'b1);
    pulse(status_read);
    chk("wrap", timer_wrap_flag, 1'b0);
    ctl.timer_hold_bit = 1'b0;
    tk(1);
    chk("tim", tval, 16'h0000);
    chk("wrap", timer_wrap_flag, 1'b1);
  endtask

  initial begin
    rst();
    t_rx();
    t_tx();
    t_remote();
    t_tt();
    t_capture();
    t_timer();
    conclude();
  end
endmodule
